// ===== include/pg_mask_pkg.sv
package pg_mask_pkg;

  // ----------------------------------------------------------------
  // widths and types
  // ----------------------------------------------------------------
  localparam int REG_W = 8;
  localparam int TREE_W = 16;
  localparam int PIN_W = 17;

  typedef logic [REG_W-1:0] reg_byte_t;
  typedef logic [TREE_W-1:0] tree_vec_t;
  typedef logic [PIN_W-1:0] pin_vec_t;

  // ----------------------------------------------------------------
  // register offsets on the parallel register strobe port
  // ----------------------------------------------------------------
  localparam reg_byte_t OFS_TWO_AUX = 8'hA9;
  localparam reg_byte_t OFS_THREE_RAIL = 8'hAA;
  localparam reg_byte_t OFS_THREE_AUX = 8'hAB;
  localparam reg_byte_t UNMAPPED_DATA = 8'h00;

  // ----------------------------------------------------------------
  // field positions in both aux mask registers
  // ----------------------------------------------------------------
  localparam int AUX_IN5 = 7;
  localparam int AUX_IN4 = 6;
  localparam int AUX_IN2 = 5;
  localparam int AUX_IN1 = 4;
  localparam int AUX_TERM = 3;
  localparam int AUX_SHARED = 2;
  localparam int AUX_SW_B1 = 1;
  localparam int AUX_LDO_A3 = 0;

  // ----------------------------------------------------------------
  // field positions in the rail mask register
  // ----------------------------------------------------------------
  localparam int RAIL_LDO_A2 = 7;
  localparam int RAIL_SW_A1 = 6;
  localparam int RAIL_STEP_HI = 5;
  localparam int RAIL_STEP_LO = 0;

  // excluded filler for the unused upper half of the second tree
  localparam reg_byte_t ALL_EXCLUDED = 8'hFF;
  localparam reg_byte_t ALL_GOOD = 8'hFF;

endpackage

// ===== include/pg_tree_if.sv
`timescale 1ns/10ps
interface pg_tree_if;
  pg_mask_pkg::tree_vec_t src;
  pg_mask_pkg::tree_vec_t exclude;
  logic good;

  modport bank (
    output src,
    output exclude,
    input good
  );

  modport tree (
    input src,
    input exclude,
    output good
  );
endinterface

// ===== test/pg_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// host side of the register strobe port
// ----------------------------------------
module pg_host_model (
  input wire logic mclk_in,
  input wire pg_mask_pkg::reg_byte_t rdata_in,
  input wire logic rvalid_in,
  output pg_mask_pkg::reg_byte_t addr_out,
  output pg_mask_pkg::reg_byte_t wdata_out,
  output logic wr_out,
  output logic rd_out
);
  import pg_mask_pkg::*;
  // idle lines
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one strobe cycle; idle lines flip so a stale value never looks valid
  task automatic strobe(input reg_byte_t a, input reg_byte_t d, input logic w);
    @(negedge mclk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = ~w;
    @(negedge mclk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic wr_reg(input reg_byte_t a, input reg_byte_t d);
    strobe(a, d, 1'b1);
  endtask
  // answer pulse stands for the cycle after the strobe edge, so it is
  // looked at on falling edges, mid-pulse; bounded wait
  task automatic rd_reg(input reg_byte_t a, output reg_byte_t d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    strobe(a, 8'h00, 1'b0);
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (rvalid_in === 1'b1)
      begin
        ok = 1'b1;
        d = rdata_in;
      end
      else
        @(negedge mclk_in);
    end
  endtask
endmodule // pg_host_model

// ===== test/test_power_good_tree_mask_bank.sv
`timescale 1ns/10ps
module test_power_good_tree_mask_bank;
  import pg_mask_pkg::*;
  // ----------------------------------------
  // stimulus state
  // ----------------------------------------
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic sel = 1'b0;
  logic sb2_x = 1'b1;
  logic la1_x = 1'b1;
  reg_byte_t aux_src = 8'hFF;
  reg_byte_t rail_src = 8'hFF;
  reg_byte_t cfg [3] = '{8'h00, 8'h00, 8'h00};
  reg_byte_t ofs [3] = '{OFS_TWO_AUX, OFS_THREE_RAIL, OFS_THREE_AUX};
  reg_byte_t addr, wdata, rdata, got;
  logic wr, rd, rvalid, ok, two, three;
  int error_cnt = 0;
  int checks_done = 0;

  always #2.5 mclk_in = ~mclk_in;

  pg_host_model i_host (.mclk_in(mclk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  // aux sources share one vector: bit n feeds aux mask bit n of both trees
  power_good_tree_mask_bank i_dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .cfg_two_aux_rst_in(cfg[0]),
    .cfg_three_rail_rst_in(cfg[1]), .cfg_three_aux_rst_in(cfg[2]),
    .shared_rail_is_ldo_in(sel), .control_input_5_in(aux_src[7]),
    .control_input_4_in(aux_src[6]), .control_input_2_in(aux_src[5]),
    .control_input_1_in(aux_src[4]), .termination_regulator_pg_in(aux_src[3]),
    .load_switch_b2_pg_in(aux_src[2] & sb2_x), .linear_reg_a1_pg_in(aux_src[2] & la1_x),
    .load_switch_b1_pg_in(aux_src[1]), .linear_reg_a3_pg_in(aux_src[0]),
    .linear_reg_a2_pg_in(rail_src[7]), .load_switch_a1_pg_in(rail_src[6]),
    .step_down_rail_pg_in(rail_src[5:0]), .pg_output_two_out(two),
    .pg_output_three_out(three));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input reg_byte_t exp, input reg_byte_t seen);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input reg_byte_t a, input reg_byte_t exp);
    i_host.rd_reg(a, got, ok);
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("BAD read answer expected 1 seen 0");
      stop_test();
    end
    else
      chk("register", exp, got);
  endtask
  // pin path is three edges deep, so four cycles always settle it
  task automatic pg_chk(input logic e2, input logic e3);
    repeat (4) @(negedge mclk_in);
    chk("pg_output_two", {7'h00, e2}, {7'h00, two});
    chk("pg_output_three", {7'h00, e3}, {7'h00, three});
  endtask
  task automatic clear_masks();
    for (int r = 0; r < 3; r++)
      i_host.wr_reg(ofs[r], 8'h00);
  endtask
  task automatic do_reset();
    rstn_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    chk("pg_output_two in reset", 8'h00, {7'h00, two});
    rstn_in = 1'b1;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    do_reset();
    for (int r = 0; r < 3; r++)
    begin
      rd_chk(ofs[r], 8'h00);
      i_host.wr_reg(ofs[r], 8'hA5 ^ 8'(r));
      rd_chk(ofs[r], 8'hA5 ^ 8'(r));
    end
    clear_masks();
    i_host.wr_reg(8'hAC, 8'h5A);
    rd_chk(8'hAC, UNMAPPED_DATA);
    $display("test registers done");
    pg_chk(1'b1, 1'b1);
    // each source dropped alone, then excluded tree by tree
    for (int b = 0; b < 8; b++)
    begin
      aux_src[b] = 1'b0;
      pg_chk(1'b0, 1'b0);
      i_host.wr_reg(OFS_TWO_AUX, 8'h01 << b);
      pg_chk(1'b1, 1'b0);
      i_host.wr_reg(OFS_THREE_AUX, 8'h01 << b);
      pg_chk(1'b1, 1'b1);
      aux_src = 8'hFF;
      rail_src[b] = 1'b0;
      pg_chk(1'b1, 1'b0);
      i_host.wr_reg(OFS_THREE_RAIL, 8'h01 << b);
      pg_chk(1'b1, 1'b1);
      rail_src = 8'hFF;
      clear_masks();
    end
    $display("test single sources done");
    // shared position follows the switch while select is low
    la1_x = 1'b0;
    pg_chk(1'b1, 1'b1);
    la1_x = 1'b1;
    sb2_x = 1'b0;
    pg_chk(1'b0, 1'b0);
    sb2_x = 1'b1;
    // everything bad but everything excluded still reads good
    for (int r = 0; r < 3; r++)
      i_host.wr_reg(ofs[r], 8'hFF);
    aux_src = 8'h00;
    rail_src = 8'h00;
    pg_chk(1'b1, 1'b1);
    aux_src = 8'hFF;
    rail_src = 8'hFF;
    $display("test shared and full mask done");
    // second reset with another configuration and the regulator selected
    cfg = '{8'h41, 8'hC3, 8'h18};
    sel = 1'b1;
    do_reset();
    for (int r = 0; r < 3; r++)
      rd_chk(ofs[r], cfg[r]);
    pg_chk(1'b1, 1'b1);
    sb2_x = 1'b0;
    pg_chk(1'b1, 1'b1);
    sb2_x = 1'b1;
    la1_x = 1'b0;
    pg_chk(1'b0, 1'b0);
    $display("test configured reset done");
    stop_test();
  end
endmodule // test_power_good_tree_mask_bank

// ===== verilog/pg_tree_eval.sv
`timescale 1ns/10ps
module pg_tree_eval (
  input wire logic mclk_in,
  input wire logic rstn_in,
  pg_tree_if.tree tree_if
);
  import pg_mask_pkg::*;

  // ----------------------------------------------------------------
  // power-good tree
  // ----------------------------------------------------------------
  logic good_ff;
  logic nxt_good;
  tree_vec_t passed;

  // an excluded source is forced good, so it cannot pull the tree low
  assign passed = tree_if.src | tree_if.exclude;
  assign nxt_good = &passed;

  // registered so the pin never sees a glitch from the and-tree
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      good_ff <= 1'b0;
    else
      good_ff <= nxt_good;
  end

  assign tree_if.good = good_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_tree_follows_sources:
    assert property (@(posedge mclk_in) disable iff (!rstn_in)
      rstn_in ##1 1'b1 |-> good_ff == &($past(tree_if.src) | $past(tree_if.exclude)))
    else $error("tree output does not match unmasked sources");

  a_excluded_low_ignored:
    assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (&(tree_if.src | tree_if.exclude)) && !(&tree_if.src) |=> good_ff)
    else $error("excluded low source pulled tree low");

endmodule // pg_tree_eval

// ===== verilog/power_good_tree_mask_bank.sv
`timescale 1ns/10ps
// Notes on behaviour
// - A9h bits 7..4 gate control inputs, output two
// - A9h bits 3..0 mask term, shared, b1, a3
// - set mask bit removes source from evaluation
// - shared bit follows configured switch or regulator
// - AAh bits 7,6 mask a2, a1 on three
// - AAh bits 5..0 mask step-down rails 6..1
// - ABh bits 7..4 gate control inputs, output three
// - ABh bits 3..0 mask term, shared, b1, a3
// - masks read/write, reset from device configuration
module power_good_tree_mask_bank (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire pg_mask_pkg::reg_byte_t reg_addr_in,
  input wire pg_mask_pkg::reg_byte_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output pg_mask_pkg::reg_byte_t reg_rdata_out,
  output logic reg_rvalid_out,
  input wire pg_mask_pkg::reg_byte_t cfg_two_aux_rst_in,
  input wire pg_mask_pkg::reg_byte_t cfg_three_rail_rst_in,
  input wire pg_mask_pkg::reg_byte_t cfg_three_aux_rst_in,
  input wire logic shared_rail_is_ldo_in,
  input wire logic control_input_1_in,
  input wire logic control_input_2_in,
  input wire logic control_input_4_in,
  input wire logic control_input_5_in,
  input wire logic termination_regulator_pg_in,
  input wire logic load_switch_b2_pg_in,
  input wire logic linear_reg_a1_pg_in,
  input wire logic load_switch_b1_pg_in,
  input wire logic linear_reg_a3_pg_in,
  input wire logic linear_reg_a2_pg_in,
  input wire logic load_switch_a1_pg_in,
  input wire logic [5:0] step_down_rail_pg_in,
  output logic pg_output_two_out,
  output logic pg_output_three_out
);
  import pg_mask_pkg::*;

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  reg_byte_t two_aux_ff;
  reg_byte_t three_rail_ff;
  reg_byte_t three_aux_ff;
  reg_byte_t rdata_ff;
  logic rvalid_ff;

  // address decode
  logic hit_two_aux;
  logic hit_three_rail;
  logic hit_three_aux;
  logic wr_two_aux;
  logic wr_three_rail;
  logic wr_three_aux;
  reg_byte_t nxt_rdata;

  assign hit_two_aux = (reg_addr_in == OFS_TWO_AUX);
  assign hit_three_rail = (reg_addr_in == OFS_THREE_RAIL);
  assign hit_three_aux = (reg_addr_in == OFS_THREE_AUX);
  assign wr_two_aux = reg_wr_in && hit_two_aux;
  assign wr_three_rail = reg_wr_in && hit_three_rail;
  assign wr_three_aux = reg_wr_in && hit_three_aux;

  // read mux; unmapped offsets read as zero
  assign nxt_rdata = hit_two_aux ? two_aux_ff :
                     hit_three_rail ? three_rail_ff :
                     hit_three_aux ? three_aux_ff : UNMAPPED_DATA;

  // reset value is whatever the configuration memory presents, not a constant
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      two_aux_ff <= cfg_two_aux_rst_in;
      three_rail_ff <= cfg_three_rail_rst_in;
      three_aux_ff <= cfg_three_aux_rst_in;
    end
    else
    begin
      if (wr_two_aux)
        two_aux_ff <= reg_wdata_in;
      if (wr_three_rail)
        three_rail_ff <= reg_wdata_in;
      if (wr_three_aux)
        three_aux_ff <= reg_wdata_in;
    end
  end

  // read answer one cycle after the strobe; data held until next read
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      rdata_ff <= UNMAPPED_DATA;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_rd_in;
      if (reg_rd_in)
        rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_vec_t raw_pins;
  pin_vec_t meta_ff;
  pin_vec_t sync_ff;

  // pins and analog comparators are asynchronous to mclk_in
  assign raw_pins = {control_input_5_in, control_input_4_in,
                     control_input_2_in, control_input_1_in,
                     termination_regulator_pg_in, load_switch_b2_pg_in,
                     linear_reg_a1_pg_in, load_switch_b1_pg_in,
                     linear_reg_a3_pg_in, linear_reg_a2_pg_in,
                     load_switch_a1_pg_in, step_down_rail_pg_in};

  // meta_ff is read by sync_ff only
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= raw_pins;
      sync_ff <= meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // named synchronised sources
  // ----------------------------------------------------------------
  logic s_in5;
  logic s_in4;
  logic s_in2;
  logic s_in1;
  logic s_term;
  logic s_sw_b2;
  logic s_ldo_a1;
  logic s_sw_b1;
  logic s_ldo_a3;
  logic s_ldo_a2;
  logic s_sw_a1;
  logic [5:0] s_step;
  logic s_shared;
  reg_byte_t aux_src;
  reg_byte_t rail_src;

  assign {s_in5, s_in4, s_in2, s_in1, s_term, s_sw_b2, s_ldo_a1,
          s_sw_b1, s_ldo_a3, s_ldo_a2, s_sw_a1, s_step} = sync_ff;

  // one mask bit covers whichever function the position was built as
  assign s_shared = shared_rail_is_ldo_in ? s_ldo_a1 : s_sw_b2;

  // aux sources share one layout between both outputs
  assign aux_src[AUX_IN5] = s_in5;
  assign aux_src[AUX_IN4] = s_in4;
  assign aux_src[AUX_IN2] = s_in2;
  assign aux_src[AUX_IN1] = s_in1;
  assign aux_src[AUX_TERM] = s_term;
  assign aux_src[AUX_SHARED] = s_shared;
  assign aux_src[AUX_SW_B1] = s_sw_b1;
  assign aux_src[AUX_LDO_A3] = s_ldo_a3;

  // rail sources; step-down rail n sits at bit n-1
  assign rail_src[RAIL_LDO_A2] = s_ldo_a2;
  assign rail_src[RAIL_SW_A1] = s_sw_a1;
  assign rail_src[RAIL_STEP_HI:RAIL_STEP_LO] = s_step;

  // ----------------------------------------------------------------
  // power-good trees
  // ----------------------------------------------------------------
  pg_tree_if tree_two ();
  pg_tree_if tree_three ();

  // output two carries only the aux sources here; its upper half is parked
  assign tree_two.src = {ALL_GOOD, aux_src};
  assign tree_two.exclude = {ALL_EXCLUDED, two_aux_ff};
  assign tree_three.src = {rail_src, aux_src};
  assign tree_three.exclude = {three_rail_ff, three_aux_ff};

  pg_tree_eval u_tree_two (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .tree_if (tree_two.tree)
  );

  pg_tree_eval u_tree_three (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .tree_if (tree_three.tree)
  );

  assign pg_output_two_out = tree_two.good;
  assign pg_output_three_out = tree_three.good;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  a_reset_loads_config:
    assert property (@(posedge mclk_in) disable iff (1'b0)
      !rstn_in |=> two_aux_ff == $past(cfg_two_aux_rst_in)
        && three_rail_ff == $past(cfg_three_rail_rst_in)
        && three_aux_ff == $past(cfg_three_aux_rst_in))
    else $error("mask did not load configuration at reset");

  a_write_two_aux:
    assert property (wr_two_aux |=> two_aux_ff == $past(reg_wdata_in))
    else $error("write to output two aux mask lost");

  a_write_three_rail:
    assert property (wr_three_rail |=> three_rail_ff == $past(reg_wdata_in))
    else $error("write to output three rail mask lost");

  a_write_three_aux:
    assert property (wr_three_aux |=> three_aux_ff == $past(reg_wdata_in))
    else $error("write to output three aux mask lost");

  a_read_returns_mask:
    assert property (reg_rd_in && hit_three_rail && !reg_wr_in
      |=> reg_rvalid_out && reg_rdata_out == $past(three_rail_ff))
    else $error("read of rail mask returned wrong data");

  a_shared_select:
    assert property (shared_rail_is_ldo_in |-> aux_src[AUX_SHARED] == s_ldo_a1)
    else $error("shared position not following regulator");

  a_term_masked_two:
    assert property (two_aux_ff == 8'h08 && !s_term ##1 two_aux_ff == 8'h08
      |-> pg_output_two_out == ($past(s_in5 && s_in4 && s_in2 && s_in1)
        && $past(s_shared && s_sw_b1 && s_ldo_a3)))
    else $error("masked termination good still affects output two");

  a_three_all_masked:
    assert property (three_rail_ff == 8'hFF && three_aux_ff == 8'hFF |=> pg_output_three_out)
    else $error("fully masked tree not reporting good");

  a_three_rail_low:
    assert property (!three_rail_ff[RAIL_LDO_A2] && !s_ldo_a2 |=> !pg_output_three_out)
    else $error("included low regulator did not drop output three");

  a_input_low_three:
    assert property (!three_aux_ff[AUX_IN1] && !s_in1 |=> !pg_output_three_out)
    else $error("included low control input did not drop output three");

endmodule // power_good_tree_mask_bank
